// ---- rtl/pdk_top.sv ----
// Serial command interpreter with keep-alive pulse generation on the TX pin.
// What this block does
// - Serial link runs at fixed 9600 bps.
// - Frame: start, eight bits LSB first, stop.
// - Device bit rate stays within 9433 to 9827.
// - Code 0x01 returns requested and granted tier.
// - Status bit 5 gives the supported pulse style.
// - Status bit 4 shows automatic tier request.
// - Status bits 2:0 give classification pulse count.
// - Status bits 7:6 and 3 send zero.
// - Code 0x03 returns voltage high then low.
// - Code 0x04 starts pulses, sends no response.
// - Code 0x05 stops pulses, restores serial use.
// - Active pulses toggle the transmit pin.
// - Pulse length follows the supported style.
// - Pulses never start without the enable command.
// - Disable command gets no response byte.
`include "pdk_consts.svh"
module pdk_top
  import pdk_pkg::*;
#(
  parameter int BIT_CYC   = `PDK_BIT_CYC,                      // Cycles per bit.
  parameter int SHORT_ON  = `PDK_US2CYC(`PDK_SHORT_ON_US),     // Short pulse high.
  parameter int SHORT_OFF = `PDK_US2CYC(`PDK_SHORT_OFF_US),    // Short pulse low.
  parameter int LONG_ON   = `PDK_US2CYC(`PDK_LONG_ON_US),      // Long pulse high.
  parameter int LONG_OFF  = `PDK_US2CYC(`PDK_LONG_OFF_US)      // Long pulse low.
) (
  input  wire logic        clk_i,        // System clock, 40 MHz.
  input  wire logic        rst_i,        // Synchronous reset, active high.
  input  wire logic        wb_cyc_i,     // Bus cycle in progress.
  input  wire logic        wb_stb_i,     // Bus strobe.
  input  wire logic        wb_we_i,      // Bus write enable.
  input  wire logic [7:0]  wb_adr_i,     // Bus byte address.
  input  wire logic [3:0]  wb_sel_i,     // Bus byte lane selects.
  input  wire logic [31:0] wb_dat_i,     // Bus write data.
  output logic      [31:0] wb_dat_o,     // Bus read data.
  output logic             wb_ack_o,     // Bus acknowledge.
  input  wire logic        rx_i,         // Serial command input.
  output logic             tx_o,         // Serial response or pulse output.
  output logic             ka_active_o   // Keep-alive generation running.
);

  // Information register: tiers, pulse style, autoclass flag, pulse count.
  logic [31:0] info_q;
  // Voltage code register, reported high byte first.
  logic [31:0] vcode_q;
  // Last command code that was taken.
  logic [7:0]  last_cmd_q;
  // Response sequencer state.
  pdk_state_t  st_q;
  // Transmit request towards the serial transmitter.
  logic        tx_start_q;
  // Byte handed to the serial transmitter.
  logic [7:0]  tx_data_q;
  // Keep-alive generation enable.
  logic        ka_q;
  // Current keep-alive pin level.
  logic        ka_lvl_q;
  // Cycles left in the current keep-alive phase.
  logic [23:0] ka_tmr_q;
  // Serial transmitter line and busy flag.
  logic        tx_line;
  logic        tx_busy;
  // Receiver byte, strobe and busy flag.
  logic [7:0]  rx_byte;
  logic        rx_valid;
  logic        rx_busy;
  // A received byte is taken as a command only when nothing is pending.
  logic        cmd_take;
  // Bus request that has not yet been answered.
  logic        wb_req;

  // Merge bus write data into a register, honouring the byte lanes.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // The status byte: reserved bits forced to zero.
  function automatic logic [7:0] status_byte(input logic [31:0] info);
    status_byte = {2'b00,
                   info[`PDK_INFO_STYLE],
                   info[`PDK_INFO_AUTO],
                   1'b0,
                   info[`PDK_INFO_CNT +: 3]};
  endfunction

  // Serial receiver for command bytes; the rate is fixed by a parameter
  // and cannot be changed from the bus.
  pdk_uart_rx #(
    .BIT_CYC (BIT_CYC)
  ) u_rx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .rx_i    (rx_i),
    .byte_o  (rx_byte),
    .valid_o (rx_valid),
    .busy_o  (rx_busy)
  );

  // Serial transmitter for response bytes; 4167 cycles give 9599 bps,
  // well inside the tolerated band of the far receiver.
  pdk_uart_tx #(
    .BIT_CYC (BIT_CYC)
  ) u_tx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tx_start_q),
    .data_i  (tx_data_q),
    .line_o  (tx_line),
    .busy_o  (tx_busy)
  );

  // Commands are only taken while no response is queued or on the line.
  assign cmd_take = rx_valid && (st_q == ST_IDLE) && !tx_busy && !tx_start_q;

  // Unanswered bus request: the answer comes one cycle after it appears.
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Bus acknowledge, one cycle per request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Writable registers, updated at the edge where the master samples ack high,
  // so a write lands exactly when the transfer completes; an unmapped address
  // ignores the write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      info_q  <= `PDK_RST_REG;
      vcode_q <= `PDK_RST_REG;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
      if (wb_adr_i == `PDK_OFS_INFO) begin
        info_q <= lane_merge(info_q, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == `PDK_OFS_VCODE) begin
        vcode_q <= lane_merge(vcode_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Read data; an unmapped address reads as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        `PDK_OFS_INFO:  wb_dat_o <= info_q;
        `PDK_OFS_VCODE: wb_dat_o <= vcode_q;
        `PDK_OFS_STATE: wb_dat_o <= {16'h0000, last_cmd_q, 5'h00, rx_busy,
                                     (st_q != ST_IDLE) || tx_busy, ka_q};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Remember the last command taken, for software to inspect.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_cmd_q <= 8'h00;
    end else if (cmd_take) begin
      last_cmd_q <= rx_byte;
    end
  end

  // Response sequencer: queues one or two bytes per read command.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q       <= ST_IDLE;
      tx_start_q <= 1'b0;
      tx_data_q  <= 8'h00;
    end else begin
      tx_start_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          // While pulses run the pin is not serial, so reads go unanswered.
          if (cmd_take && !ka_q) begin
            case (rx_byte)
              `PDK_CMD_TIER: begin
                tx_start_q <= 1'b1;
                tx_data_q  <= info_q[7:0];
                st_q       <= ST_BUSY;
              end
              `PDK_CMD_STATUS: begin
                tx_start_q <= 1'b1;
                tx_data_q  <= status_byte(info_q);
                st_q       <= ST_BUSY;
              end
              `PDK_CMD_VOLT: begin
                tx_start_q <= 1'b1;
                tx_data_q  <= vcode_q[15:8];
                st_q       <= ST_SECOND;
              end
              default: begin
                // Enable, disable and unknown codes send nothing.
                st_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_SECOND: begin
          // Second voltage byte follows once the first has been sent.
          if (!tx_busy && !tx_start_q) begin
            tx_start_q <= 1'b1;
            tx_data_q  <= vcode_q[7:0];
            st_q       <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          // Wait for the last byte to leave before taking a new command.
          if (!tx_busy && !tx_start_q) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Keep-alive enable: set only by the host's enable command, cleared by its disable command or by reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ka_q <= 1'b0;
    end else if (cmd_take && rx_byte == `PDK_CMD_KA_ON) begin
      ka_q <= 1'b1;
    end else if (cmd_take && rx_byte == `PDK_CMD_KA_OFF) begin
      ka_q <= 1'b0;
    end
  end

  // Pulse timer: high and low phase lengths follow the supported style.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ka_lvl_q <= 1'b1;
      ka_tmr_q <= 24'h000000;
    end else if (!ka_q) begin
      // Start each run with a fresh high phase.
      ka_lvl_q <= 1'b1;
      ka_tmr_q <= info_q[`PDK_INFO_STYLE] ? 24'(SHORT_ON - 1)
                                          : 24'(LONG_ON - 1);
    end else if (ka_tmr_q != 24'h000000) begin
      ka_tmr_q <= ka_tmr_q - 24'h000001;
    end else begin
      ka_lvl_q <= !ka_lvl_q;
      if (ka_lvl_q) begin
        ka_tmr_q <= info_q[`PDK_INFO_STYLE] ? 24'(SHORT_OFF - 1)
                                            : 24'(LONG_OFF - 1);
      end else begin
        ka_tmr_q <= info_q[`PDK_INFO_STYLE] ? 24'(SHORT_ON - 1)
                                            : 24'(LONG_ON - 1);
      end
    end
  end

  // Output pin: pulse level while keep-alive runs, serial line otherwise.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
    end else begin
      tx_o <= ka_q ? ka_lvl_q : tx_line;
    end
  end

  // Keep-alive state mirrored to a pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ka_active_o <= 1'b0;
    end else begin
      ka_active_o <= ka_q;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A command byte taken from the receiver.
  sequence s_cmd(logic [7:0] code);
    cmd_take && !ka_q && rx_byte == code;
  endsequence

  // The first voltage byte queued while, in the same cycle, the sequencer waits to send more.
  sequence s_volt_hi;
    tx_start_q && tx_data_q == vcode_q[15:8] && st_q == ST_SECOND;
  endsequence

  a_ka_self_start : assert property ($rose(ka_q) |->
      $past(cmd_take && rx_byte == `PDK_CMD_KA_ON))
    else $error("Keep-alive started without the enable command.");

  a_ka_stop_cmd : assert property (cmd_take && rx_byte == `PDK_CMD_KA_OFF
      |=> !ka_q ##1 !ka_active_o)
    else $error("Keep-alive still active after the disable command.");

  a_ka_no_answer : assert property (cmd_take && (rx_byte == `PDK_CMD_KA_ON ||
      rx_byte == `PDK_CMD_KA_OFF) |=> !tx_start_q [*2])
    else $error("Enable or disable command produced a response.");

  a_ka_pin_high : assert property ($rose(ka_q) |=> tx_o [*4])
    else $error("Keep-alive run did not begin with a high phase.");

  a_tier_reply : assert property (s_cmd(`PDK_CMD_TIER) |=>
      tx_start_q && tx_data_q == {info_q[7:4], info_q[3:0]})
    else $error("Tier query answered with the wrong byte.");

  a_status_reply : assert property (s_cmd(`PDK_CMD_STATUS) |=>
      tx_start_q && tx_data_q[7:6] == 2'b00 && !tx_data_q[3]
      && tx_data_q[5] == info_q[`PDK_INFO_STYLE])
    else $error("Status byte has wrong style bit or nonzero reserved bits.");

  a_volt_order : assert property (s_cmd(`PDK_CMD_VOLT) |=> s_volt_hi
      ##1 !tx_start_q [*2])
    else $error("Voltage high byte not queued first.");

  a_volt_second : assert property (st_q == ST_SECOND && !tx_busy
      && !tx_start_q |=> tx_start_q && tx_data_q == $past(vcode_q[7:0]))
    else $error("Voltage low byte not queued after the high byte.");

  a_unknown_cmd : assert property (cmd_take && (rx_byte == 8'h00 ||
      rx_byte > `PDK_CMD_KA_OFF) |=> !tx_start_q && $stable(ka_q))
    else $error("Unknown command code caused a reaction.");

  a_idle_line : assert property (st_q == ST_IDLE && !tx_busy
      && !tx_start_q && !ka_q [*2] |=> tx_o)
    else $error("Transmit pin low while idle.");

  a_wb_ack_once : assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Bus acknowledge held longer than one cycle.");

endmodule // pdk_top

// ---- rtl/pdk_consts.svh ----
// Constants for the keep-alive command interpreter: timing, codes, offsets.
`ifndef PDK_CONSTS_SVH
`define PDK_CONSTS_SVH
// System clock rate and the fixed serial bit rate.
`define PDK_CLK_HZ        40000000
`define PDK_BAUD_BPS      9600
// Cycles per bit time, rounded to nearest: 4167 cycles, 9599 bps.
`define PDK_BIT_CYC       ((`PDK_CLK_HZ + `PDK_BAUD_BPS / 2) / `PDK_BAUD_BPS)
// Keep-alive pulse high and low times in microseconds.
`define PDK_SHORT_ON_US   10000
`define PDK_SHORT_OFF_US  290000
`define PDK_LONG_ON_US    80000
`define PDK_LONG_OFF_US   220000
// Microseconds to clock cycles, scaled first to avoid 32-bit overflow.
`define PDK_US2CYC(t)     ((t) * (`PDK_CLK_HZ / 1000000))
// Command codes received on the serial input.
`define PDK_CMD_TIER      8'h01
`define PDK_CMD_STATUS    8'h02
`define PDK_CMD_VOLT      8'h03
`define PDK_CMD_KA_ON     8'h04
`define PDK_CMD_KA_OFF    8'h05
// Register byte offsets on the bus.
`define PDK_OFS_INFO      8'h00
`define PDK_OFS_VCODE     8'h04
`define PDK_OFS_STATE     8'h08
// Field positions inside the information register.
`define PDK_INFO_STYLE    8
`define PDK_INFO_AUTO     9
`define PDK_INFO_CNT      12
// Reset value of the writable registers.
`define PDK_RST_REG       32'h0000_0000
`endif

// ---- rtl/pdk_pkg.sv ----
// Types shared by the keep-alive command interpreter.
package pdk_pkg;
  // Response sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SECOND,
    ST_BUSY
  } pdk_state_t;
endpackage

// ---- rtl/pdk_uart_tx.sv ----
// Serial transmitter: one start bit, eight data bits LSB first, one stop bit.
module pdk_uart_tx #(
  parameter int BIT_CYC = 4167  // Clock cycles per bit time.
) (
  input  wire logic       clk_i,    // System clock.
  input  wire logic       rst_i,    // Synchronous reset, active high.
  input  wire logic       start_i,  // Pulse: send data_i when idle.
  input  wire logic [7:0] data_i,   // Byte to send.
  output logic            line_o,   // Serial line, idle high.
  output logic            busy_o    // High while a frame is on the way.
);
  logic [9:0]  shf_q;  // Frame bits still to send.
  logic [3:0]  cnt_q;  // Bits already finished.
  logic [15:0] tmr_q;  // Cycle count inside a bit.

  // Load the ten-bit frame and shift it out one bit time at a time.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      shf_q  <= 10'h3FF;
      cnt_q  <= 4'h0;
      tmr_q  <= 16'h0000;
    end else if (!busy_o) begin
      if (start_i) begin
        busy_o <= 1'b1;
        shf_q  <= {1'b1, data_i, 1'b0};
        cnt_q  <= 4'h0;
        tmr_q  <= 16'h0000;
      end
    end else if (tmr_q == 16'(BIT_CYC - 1)) begin
      tmr_q <= 16'h0000;
      shf_q <= {1'b1, shf_q[9:1]};
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'h9) begin
        busy_o <= 1'b0;
      end
    end else begin
      tmr_q <= tmr_q + 16'h0001;
    end
  end

  // The line shows the current frame bit, or idle high between frames.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_o <= 1'b1;
    end else begin
      line_o <= busy_o ? shf_q[0] : 1'b1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_tx_start_bit : assert property (start_i && !busy_o |=> ##1 !line_o [*4])
    else $error("Start bit not sent after accepted start.");
endmodule // pdk_uart_tx

// ---- rtl/pdk_uart_rx.sv ----
// Serial receiver: samples each bit at its centre and checks the stop bit.
module pdk_uart_rx #(
  parameter int BIT_CYC = 4167  // Clock cycles per bit time.
) (
  input  wire logic       clk_i,    // System clock.
  input  wire logic       rst_i,    // Synchronous reset, active high.
  input  wire logic       rx_i,     // Serial line, idle high.
  output logic [7:0]      byte_o,   // Last received byte.
  output logic            valid_o,  // Pulse: byte_o holds a new byte.
  output logic            busy_o    // High while a frame is being read.
);
  logic [3:0]  cnt_q;  // Bit index: 0 start, 1 to 8 data, 9 stop.
  logic [15:0] tmr_q;  // Cycles left until the next sample point.

  // Find a start edge, then sample every bit centre of the frame.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o  <= 1'b0;
      byte_o  <= 8'h00;
      valid_o <= 1'b0;
      cnt_q   <= 4'h0;
      tmr_q   <= 16'h0000;
    end else begin
      valid_o <= 1'b0;
      if (!busy_o) begin
        if (!rx_i) begin
          busy_o <= 1'b1;
          cnt_q  <= 4'h0;
          tmr_q  <= 16'(BIT_CYC / 2);
        end
      end else if (tmr_q != 16'h0000) begin
        tmr_q <= tmr_q - 16'h0001;
      end else begin
        tmr_q <= 16'(BIT_CYC - 1);
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q == 4'h0) begin
          // A start bit that is high again at its centre was a glitch.
          busy_o <= !rx_i;
        end else if (cnt_q == 4'h9) begin
          // A low stop bit is a framing error and the byte is dropped.
          busy_o  <= 1'b0;
          valid_o <= rx_i;
        end else begin
          byte_o <= {rx_i, byte_o[7:1]};
        end
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_rx_valid_pulse : assert property (valid_o |=> !valid_o)
    else $error("Receive strobe longer than one cycle.");
endmodule // pdk_uart_rx

// ---- tb/pdk_host_model.sv ----
// Host-side serial partner: sends command frames and collects device frames.
module pdk_host_model #(
  parameter int BIT_CYC = 16  // Clock cycles per bit time.
) (
  input  wire logic clk_i,   // System clock.
  input  wire logic line_i,  // Device transmit line.
  output logic      line_o   // Host transmit line into the device.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rxq[$];    // Bytes collected from the device.
  int         bad_stop;  // Frames whose stop bit read low.
  bit         ignore;    // Set while keep-alive pulses make the line invalid.
  logic [7:0] prev;      // Byte collected just before the latest one.
  int         mv;        // Millivolts from the last two bytes, high byte first.

  // The line starts idle high, nothing is ignored yet.
  initial begin
    line_o   = 1'b1;
    ignore   = 1'b0;
    bad_stop = 0;
    prev     = 8'h00;
    mv       = 0;
  end

  // Sends one frame of start bit, eight bits LSB first and stop bit.
  task automatic send_byte(input logic [7:0] b);
    line_o <= 1'b0;
    repeat (BIT_CYC) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      line_o <= b[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (BIT_CYC) @(posedge clk_i);
    if (b == 8'h04) ignore = 1'b1;
    if (b == 8'h05) ignore = 1'b0;
  endtask

  // Reads device frames at each bit centre unless pulses are running.
  always begin
    logic [7:0] b;  // Byte being assembled.
    @(negedge line_i);
    if (!ignore) begin
      repeat (BIT_CYC / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk_i);
        b[i] = line_i;
      end
      repeat (BIT_CYC) @(posedge clk_i);
      if (line_i !== 1'b1) bad_stop++;
      rxq.push_back(b);
      // The host turns the last high and low byte into millivolts.
      mv = (prev * 256 + b) * 1482 / 10 + 11830;
      prev = b;
    end
  end
endmodule  // pdk_host_model

// ---- tb/pdk_top_test.sv ----
// Self-checking bench for the keep-alive command interpreter.
`include "pdk_consts.svh"
module pdk_top_test;
  import pdk_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT = 16;  // Shortened bit time.
  localparam int S_ON = 20;  // Short high phase.
  localparam int L_ON = 30;  // Long high phase.
  logic        clk;  // System clock.
  logic        rst;  // Synchronous reset.
  logic        cyc, stb, we;  // Bus controls.
  logic [7:0]  adr;  // Bus address.
  logic [3:0]  sel;  // Bus lanes.
  logic [31:0] wdat, rdat, q;  // Bus data and read result.
  logic        ack, rx, tx, ka;  // Bus answer and serial pins.
  logic [31:0] info_m, vcode_m;  // Bench model of the two registers.
  int          fails, checks, len;  // Counters and measured length.

  pdk_top #(.BIT_CYC(BIT), .SHORT_ON(S_ON), .SHORT_OFF(40), .LONG_ON(L_ON),
    .LONG_OFF(60)) u_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rx_i(rx), .tx_o(tx), .ka_active_o(ka));
  pdk_host_model #(.BIT_CYC(BIT)) u_host (.clk_i(clk), .line_i(tx), .line_o(rx));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("Checks %0d, fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Compare tasks, one per kind of result.
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
    cmp_word({24'h0, g}, {24'h0, e});
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask

  // One classic bus cycle; held until ack is sampled high.
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= d;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (w && s[i] && a == `PDK_OFS_INFO) info_m[8*i +: 8] = d[8*i +: 8];
      if (w && s[i] && a == `PDK_OFS_VCODE) vcode_m[8*i +: 8] = d[8*i +: 8];
    end
    @(posedge clk);
  endtask

  // Reads a register and compares it with the bench model, VCODE on bits 15:0 only, unmapped ones with zero.
  task automatic chk_rd(input logic [7:0] a);
    wb_xfer(1'b0, a, 32'h0, 4'hF);
    if (a == `PDK_OFS_INFO) cmp_word(q, info_m);
    else if (a == `PDK_OFS_VCODE) cmp_word({16'h0, q[15:0]}, {16'h0, vcode_m[15:0]});
    else cmp_word(q, 32'h0);
  endtask

  // Sends a command and checks every answered byte against the model.
  task automatic run_cmd(input logic [7:0] c);
    logic [7:0] e[$];
    int k;
    case (c)
      `PDK_CMD_TIER: e.push_back(info_m[7:0]);
      `PDK_CMD_STATUS: e.push_back({2'b00, info_m[8], info_m[9], 1'b0, info_m[14:12]});
      `PDK_CMD_VOLT: e = '{vcode_m[15:8], vcode_m[7:0]};
      default: e = {};
    endcase
    if (ka === 1'b1) e = {};
    u_host.send_byte(c);
    k = 0;
    while (u_host.rxq.size() < e.size() && k < 30 * BIT) begin
      @(posedge clk);
      k++;
    end
    repeat (12 * BIT) @(posedge clk);
    cmp_word(u_host.rxq.size(), e.size());
    foreach (e[i]) cmp_byte(u_host.rxq.pop_front(), e[i]);
    cmp_word(u_host.bad_stop, 0);
  endtask

  // Measures the next full high phase of the pulse train.
  task automatic meas_high();
    int n;
    n = 0;
    while (tx === 1'b1 && n < 200) begin @(posedge clk); n++; end
    while (tx !== 1'b1 && n < 400) begin @(posedge clk); n++; end
    len = 0;
    while (tx === 1'b1 && len < 200) begin @(posedge clk); len++; end
  endtask

  // Cuts a hang short.
  initial begin
    #(25 * 60000);
    fails++;
    test_done();
  end

  // Main sequence.
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
    wdat = 32'h0; info_m = 32'h0; vcode_m = 32'h0; fails = 0; checks = 0;
    void'($urandom(70930));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    cmp_bit(tx, 1'b1);
    cmp_bit(ka, 1'b0);
    cmp_bit((40000000 / `PDK_BIT_CYC) inside {[9433:9827]}, 1'b1);
    chk_rd(`PDK_OFS_INFO);
    chk_rd(`PDK_OFS_VCODE);
    for (int it = 0; it < 4; it++) begin
      wb_xfer(1'b1, `PDK_OFS_INFO, $urandom(), 4'hF);
      wb_xfer(1'b1, `PDK_OFS_VCODE, $urandom(), (it == 3) ? 4'h1 : 4'hF);
      chk_rd(`PDK_OFS_INFO);
      chk_rd(`PDK_OFS_VCODE);
      run_cmd(`PDK_CMD_TIER);
      run_cmd(`PDK_CMD_STATUS);
      run_cmd(`PDK_CMD_VOLT);
      cmp_word(u_host.mv, vcode_m[15:0] * 1482 / 10 + 11830);
    end
    wb_xfer(1'b1, 8'h0C, $urandom(), 4'hF);
    chk_rd(8'h0C);
    for (int u = 0; u < 3; u++) begin
      run_cmd((u == 0) ? 8'h00 : (u == 1) ? 8'h06 : 8'($urandom_range(255, 6)));
    end
    cmp_bit(ka, 1'b0);
    wb_xfer(1'b1, `PDK_OFS_INFO, info_m | 32'h100, 4'hF);
    run_cmd(`PDK_CMD_KA_ON);
    cmp_bit(ka, 1'b1);
    wb_xfer(1'b0, `PDK_OFS_STATE, 32'h0, 4'hF);
    cmp_word({q[15:8], 7'h0, q[0]}, {`PDK_CMD_KA_ON, 8'h01});
    meas_high();
    cmp_bit(len inside {[S_ON - 1:S_ON + 1]}, 1'b1);
    wb_xfer(1'b1, `PDK_OFS_INFO, info_m & ~32'h100, 4'hF);
    meas_high();
    cmp_bit(len inside {[L_ON - 1:L_ON + 1]}, 1'b1);
    run_cmd(`PDK_CMD_TIER);
    run_cmd(`PDK_CMD_KA_OFF);
    cmp_bit(ka, 1'b0);
    cmp_bit(tx, 1'b1);
    run_cmd(`PDK_CMD_STATUS);
    test_done();
  end
endmodule  // pdk_top_test
